// ===== rtl/hpp_pkg.sv
// Constants and register map of the host port pad control block
//
// Contract
// [RQ1] In wide host mode, external address pins pick internal memory words for host accesses.
// [RQ2] In wide host mode, sixteen external data pins carry host reads and writes.
// [RQ3] External data pins float unless driving, in reset, bus hold, or output disable low.
// [RQ4] Enabled keepers hold external data lines at the level last driven.
// [RQ5] Data keepers are off at reset; a control register bit switches them.
// [RQ6] Eight host data pins; in wide host mode they become general-purpose I/O.
// [RQ7] Host data pins float unless outputting data, and whenever output disable is low.
// [RQ8] Host keepers are off at reset; a separate control bit switches them.
// [RQ9] Line interface is enabled only while its active-low enable input is low.
// [RQ10] Host holds its select low for the whole of every host port access.
// [RQ11] In narrow mode, address and data pins serve memory; host uses eight data pins.
package hpp_pkg;
	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [3:0] ADDR_BUS_SWITCH_CONTROL_REG = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_GPIO_OUT = 4'h8;
	localparam logic [3:0] ADDR_GPIO_DIR = 4'hC;
	// ----------------------------------------
	// Fields of bus_switch_control_reg
	// ----------------------------------------
	localparam int DATA_KEEPER_BIT = 1;
	localparam int HOST_KEEPER_BIT = 2;
	localparam logic [31:0] BUS_SWITCH_CONTROL_REG_RESET = 32'h0000_0000;
	// ----------------------------------------
	// Fields of the status register
	// ----------------------------------------
	localparam int ST_WIDE_BIT = 0;
	localparam int ST_LINE_BIT = 1;
	localparam int ST_HOLD_BIT = 2;
	localparam int ST_OFF_BIT = 3;
	localparam int ST_SEL_BIT = 4;
	localparam logic [7:0] GPIO_RESET = 8'h00;
endpackage

// ===== rtl/hpp_keeper.sv
// Bus-holder model for a group of pads
`timescale 1ns/100ps
module hpp_keeper #(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic [WIDTH-1:0] drive_val,
	input wire logic [WIDTH-1:0] drive_en,
	output logic [WIDTH-1:0] keep_val,
	output logic [WIDTH-1:0] keep_en
);
	// Elaboration-time check: a keeper group needs at least one line
	if (WIDTH < 1) begin : g_bad_width
		$error("hpp_keeper: WIDTH must be positive");
	end

	logic [WIDTH-1:0] last_q;

	// Remember the level last driven on each line
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			last_q <= '0;
		end else begin
			last_q <= (drive_en & drive_val) | (~drive_en & last_q);
		end
	end

	// Keeper only acts on lines that nobody inside drives
	assign keep_val = last_q; // RQ4
	assign keep_en = enable ? ~drive_en : '0; // RQ4
endmodule

// ===== rtl/hpp_top.sv
// Host port pad control: pin routing, float conditions, keepers
//
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
module hpp_top #(
	parameter int AW = 16,
	parameter int DW = 16,
	parameter int HW = 8
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	// Wishbone classic slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [3:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Mode and control pins
	input wire logic WIDE_HOST_MODE_PIN,
	input wire logic OUTPUT_ENABLE_N,
	input wire logic BUS_HOLD,
	input wire logic LINE_INTERFACE_ENABLE_N,
	input wire logic HOST_SELECT_N,
	output logic LINE_INTERFACE_ON,
	// External address pins
	input wire logic [AW-1:0] EXT_ADDRESS_PINS,
	// External data pins
	input wire logic [DW-1:0] EXT_DATA_PINS_I,
	output logic [DW-1:0] EXT_DATA_PINS_O,
	output logic [DW-1:0] EXT_DATA_PINS_OE,
	output logic [DW-1:0] EXT_DATA_KEEP_O,
	output logic [DW-1:0] EXT_DATA_KEEP_OE,
	// Host data pins
	input wire logic [HW-1:0] HOST_DATA_PINS_I,
	output logic [HW-1:0] HOST_DATA_PINS_O,
	output logic [HW-1:0] HOST_DATA_PINS_OE,
	output logic [HW-1:0] HOST_DATA_KEEP_O,
	output logic [HW-1:0] HOST_DATA_KEEP_OE,
	// Core memory interface side
	input wire logic MEM_DRIVE,
	input wire logic [DW-1:0] MEM_WDATA,
	output logic [DW-1:0] MEM_RDATA,
	// Host port core side
	input wire logic HOST_DRIVE,
	input wire logic [DW-1:0] HOST_RDATA,
	output logic HOST_WIDE,
	output logic HOST_ACTIVE,
	output logic [AW-1:0] HOST_ADDR,
	output logic [DW-1:0] HOST_WDATA,
	output logic [HW-1:0] GPIO_IN
);
	// Elaboration-time check: registers are 32 bits and host pins fold into the data bus
	if (HW > DW || DW > 32 || AW > 32 || HW < 1) begin : g_bad_widths
		$error("hpp_top: bad widths");
	end

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	logic ack_q;
	logic [31:0] rdat_q;
	logic data_keep_q;
	logic host_keep_q;
	logic [HW-1:0] gpio_out_q;
	logic [HW-1:0] gpio_dir_q;

	wire req = WB_CYC_I && WB_STB_I && !ack_q;
	wire wr = req && WB_WE_I && WB_SEL_I[0];
	wire hit_bus_switch_control_reg = WB_ADR_I == hpp_pkg::ADDR_BUS_SWITCH_CONTROL_REG;
	wire hit_stat = WB_ADR_I == hpp_pkg::ADDR_STATUS;
	wire hit_gout = WB_ADR_I == hpp_pkg::ADDR_GPIO_OUT;
	wire hit_gdir = WB_ADR_I == hpp_pkg::ADDR_GPIO_DIR;

	wire [31:0] bus_switch_control_reg_rd = {29'h0, host_keep_q, data_keep_q, 1'b0};
	wire [31:0] stat_rd = {27'h0, !HOST_SELECT_N, !OUTPUT_ENABLE_N, BUS_HOLD,
		LINE_INTERFACE_ON, WIDE_HOST_MODE_PIN};
	wire [31:0] gout_rd = 32'(gpio_out_q);
	wire [31:0] gdir_rd = 32'(gpio_dir_q);
	// Unmapped offsets are acknowledged and read as zero
	wire [31:0] rd_mux = hit_bus_switch_control_reg ? bus_switch_control_reg_rd :
		hit_stat ? stat_rd :
		hit_gout ? gout_rd :
		hit_gdir ? gdir_rd : 32'h0000_0000;

	// One wait state: ack in the cycle after the request is seen
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			rdat_q <= req ? rd_mux : rdat_q;
		end
	end
	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = rdat_q;

	// Keepers come up disabled
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			data_keep_q <= hpp_pkg::BUS_SWITCH_CONTROL_REG_RESET[hpp_pkg::DATA_KEEPER_BIT]; // RQ5
			host_keep_q <= hpp_pkg::BUS_SWITCH_CONTROL_REG_RESET[hpp_pkg::HOST_KEEPER_BIT]; // RQ8
		end else if (wr && hit_bus_switch_control_reg) begin
			data_keep_q <= WB_DAT_I[hpp_pkg::DATA_KEEPER_BIT]; // RQ5
			host_keep_q <= WB_DAT_I[hpp_pkg::HOST_KEEPER_BIT]; // RQ8
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			gpio_out_q <= hpp_pkg::GPIO_RESET;
			gpio_dir_q <= hpp_pkg::GPIO_RESET;
		end else begin
			if (wr && hit_gout) gpio_out_q <= WB_DAT_I[HW-1:0];
			if (wr && hit_gdir) gpio_dir_q <= WB_DAT_I[HW-1:0];
		end
	end

	// ----------------------------------------
	// Pin routing
	// ----------------------------------------
	wire wide = WIDE_HOST_MODE_PIN;
	wire sel = !HOST_SELECT_N;
	// Shared bus is silent in reset, bus hold or with outputs disabled
	wire ext_quiet = !RST_N || BUS_HOLD || OUTPUT_ENABLE_N == 1'b0; // RQ3
	// In narrow mode only the memory interface may drive the wide bus
	wire ext_drive = wide ? (sel && HOST_DRIVE) : MEM_DRIVE; // RQ2 RQ11
	wire [DW-1:0] ext_val = wide ? HOST_RDATA : MEM_WDATA; // RQ2 RQ11
	wire host_drive_n = !wide && sel && HOST_DRIVE; // RQ11
	wire [HW-1:0] host_oe = wide ? gpio_dir_q : {HW{host_drive_n}}; // RQ6
	wire [HW-1:0] host_val = wide ? gpio_out_q : HOST_RDATA[HW-1:0]; // RQ6
	wire [DW-1:0] ext_oe_w = ext_quiet ? '0 : {DW{ext_drive}}; // RQ3
	wire [HW-1:0] host_oe_w = OUTPUT_ENABLE_N ? host_oe : '0; // RQ7

	assign EXT_DATA_PINS_O = ext_val;
	assign EXT_DATA_PINS_OE = ext_oe_w;
	assign HOST_DATA_PINS_O = host_val;
	assign HOST_DATA_PINS_OE = host_oe_w;

	assign MEM_RDATA = EXT_DATA_PINS_I;
	assign HOST_WIDE = wide;
	// Host drives its select low across the whole access
	assign HOST_ACTIVE = sel; // RQ10
	assign HOST_ADDR = wide ? EXT_ADDRESS_PINS : '0; // RQ1
	assign HOST_WDATA = wide ? EXT_DATA_PINS_I :
		{{(DW-HW){1'b0}}, HOST_DATA_PINS_I}; // RQ2 RQ11
	assign GPIO_IN = wide ? HOST_DATA_PINS_I : '0; // RQ6
	assign LINE_INTERFACE_ON = !LINE_INTERFACE_ENABLE_N; // RQ9

	// ----------------------------------------
	// Keepers
	// ----------------------------------------
	hpp_keeper #(.WIDTH(DW)) u_ext_keep (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.enable(data_keep_q),
		.drive_val(ext_val),
		.drive_en(ext_oe_w),
		.keep_val(EXT_DATA_KEEP_O),
		.keep_en(EXT_DATA_KEEP_OE)
	);

	hpp_keeper #(.WIDTH(HW)) u_host_keep (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.enable(host_keep_q),
		.drive_val(host_val),
		.drive_en(host_oe_w),
		.keep_val(HOST_DATA_KEEP_O),
		.keep_en(HOST_DATA_KEEP_OE)
	);
endmodule

// ===== test/hpp_sva.sv
// Checker for pad routing, float and keeper behaviour
`timescale 1ns/100ps
module hpp_sva (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic WIDE_HOST_MODE_PIN,
	input wire logic OUTPUT_ENABLE_N,
	input wire logic BUS_HOLD,
	input wire logic LINE_INTERFACE_ENABLE_N,
	input wire logic LINE_INTERFACE_ON,
	input wire logic [15:0] EXT_ADDRESS_PINS,
	input wire logic [15:0] EXT_DATA_PINS_I,
	input wire logic [15:0] EXT_DATA_PINS_O,
	input wire logic [15:0] EXT_DATA_PINS_OE,
	input wire logic [15:0] EXT_DATA_KEEP_O,
	input wire logic [15:0] EXT_DATA_KEEP_OE,
	input wire logic [7:0] HOST_DATA_PINS_I,
	input wire logic [7:0] HOST_DATA_PINS_OE,
	input wire logic [15:0] HOST_ADDR,
	input wire logic [15:0] HOST_WDATA,
	input wire logic [7:0] GPIO_IN
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	AST_LINE: assert property (LINE_INTERFACE_ON == !LINE_INTERFACE_ENABLE_N)
		else $error("line enable wrong");
	AST_EXT_OFF: assert property ((!OUTPUT_ENABLE_N || BUS_HOLD) |-> EXT_DATA_PINS_OE == 16'h0000)
		else $error("ext pads driven");
	AST_HOST_OFF: assert property (!OUTPUT_ENABLE_N |-> HOST_DATA_PINS_OE == 8'h00)
		else $error("host pads driven");
	AST_KEEP_VAL: assert property (&EXT_DATA_PINS_OE |=> EXT_DATA_KEEP_O == $past(EXT_DATA_PINS_O))
		else $error("keeper value stale");
	AST_KEEP_OVL: assert property ((EXT_DATA_KEEP_OE & EXT_DATA_PINS_OE) == 16'h0000)
		else $error("keeper fights driver");
	AST_WIDE: assert property (WIDE_HOST_MODE_PIN |-> HOST_ADDR == EXT_ADDRESS_PINS)
		else $error("host address wrong");
	AST_GPIO: assert property (WIDE_HOST_MODE_PIN |-> GPIO_IN == HOST_DATA_PINS_I && HOST_WDATA == EXT_DATA_PINS_I)
		else $error("wide routing wrong");
	AST_NARROW: assert property (!WIDE_HOST_MODE_PIN |-> HOST_ADDR == 16'h0000 && GPIO_IN == 8'h00)
		else $error("narrow routing wrong");
endmodule

// ===== test/hpp_host_model.sv
// Behavioural external host driving the data pins
`timescale 1ns/100ps
module hpp_host_model (
	input wire logic clk,
	input wire logic start,
	input wire logic [15:0] data,
	output logic sel_n,
	output logic [15:0] bus
);
	initial begin
		sel_n = 1'b1;
		bus = 16'h0000;
	end
	always @(posedge clk) begin
		if (start && sel_n) begin
			sel_n <= 1'b0;
			bus <= data;
			repeat (4) @(posedge clk);
			sel_n <= 1'b1;
			// Released bus shows the inverse so stale data cannot pass
			bus <= ~data;
		end
	end
endmodule

// ===== test/hpp_top_tb.sv
// Self-checking bench for the host port pad control block
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
module hpp_top_tb;
	logic REF_CLK = 1'b0, RST_N = 1'b0, WB_CYC_I = 1'b0, WB_STB_I, WB_WE_I = 1'b0, start = 1'b0;
	logic WIDE_HOST_MODE_PIN = 1'b0, OUTPUT_ENABLE_N = 1'b1, BUS_HOLD = 1'b0, HOST_DRIVE = 1'b0;
	logic LINE_INTERFACE_ENABLE_N = 1'b1, MEM_DRIVE = 1'b0, HOST_SELECT_N, sel_n;
	logic [3:0] WB_ADR_I = 4'h0, WB_SEL_I = 4'hF;
	logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, rd;
	logic [15:0] EXT_ADDRESS_PINS = 16'h1234, MEM_WDATA = 16'hA5C3, HOST_RDATA = 16'h0000, mbus;
	logic [15:0] EXT_DATA_PINS_I, EXT_DATA_PINS_O, EXT_DATA_PINS_OE, EXT_DATA_KEEP_O;
	logic [15:0] EXT_DATA_KEEP_OE, MEM_RDATA, HOST_ADDR, HOST_WDATA;
	logic [7:0] HOST_DATA_PINS_I, HOST_DATA_PINS_O, HOST_DATA_PINS_OE, HOST_DATA_KEEP_O;
	logic [7:0] HOST_DATA_KEEP_OE, GPIO_IN;
	logic WB_ACK_O, LINE_INTERFACE_ON, HOST_WIDE, HOST_ACTIVE;
	int err_count = 0, compares = 0;
	assign WB_STB_I = WB_CYC_I;
	assign HOST_SELECT_N = sel_n;
	// A selected host overrides the weak keeper
	assign EXT_DATA_PINS_I = EXT_DATA_PINS_OE & EXT_DATA_PINS_O | ~EXT_DATA_PINS_OE & (sel_n ?
		EXT_DATA_KEEP_OE & EXT_DATA_KEEP_O | ~EXT_DATA_KEEP_OE & mbus : mbus);
	assign HOST_DATA_PINS_I = HOST_DATA_PINS_OE & HOST_DATA_PINS_O | ~HOST_DATA_PINS_OE & (sel_n ?
		HOST_DATA_KEEP_OE & HOST_DATA_KEEP_O | ~HOST_DATA_KEEP_OE & mbus[7:0] : mbus[7:0]);
	hpp_top uut (.*);
	hpp_host_model host (.clk(REF_CLK), .start(start), .data(16'hBEEF), .sel_n(sel_n), .bus(mbus));
	always #5 REF_CLK = ~REF_CLK;
	task automatic finish_test();
		if (err_count == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		WB_CYC_I <= 1'b1;
		WB_WE_I <= w;
		WB_ADR_I <= a;
		WB_DAT_I <= d;
		do begin
			@(posedge REF_CLK);
			n++;
		end while (WB_ACK_O !== 1'b1 && n < 20);
		rd = WB_DAT_O;
		WB_CYC_I <= 1'b0;
		if (n >= 20) begin
			err_count++;
			finish_test();
		end
		@(posedge REF_CLK);
	endtask
	task automatic t_regs();
		`CHK("keep oe", 16'h0000, EXT_DATA_KEEP_OE)
		`CHK("hkeep oe", 8'h00, HOST_DATA_KEEP_OE)
		wb(1'b0, hpp_pkg::ADDR_BUS_SWITCH_CONTROL_REG, 32'h0);
		`CHK("bus_switch_control_reg", hpp_pkg::BUS_SWITCH_CONTROL_REG_RESET, rd)
		wb(1'b1, hpp_pkg::ADDR_BUS_SWITCH_CONTROL_REG, 32'h0000_0006);
		wb(1'b0, 4'h2, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		wb(1'b0, hpp_pkg::ADDR_BUS_SWITCH_CONTROL_REG, 32'h0);
		`CHK("bus_switch_control_reg wr", 32'h0000_0006, rd)
	endtask
	task automatic t_pads();
		MEM_DRIVE <= 1'b1;
		@(posedge REF_CLK);
		`CHK("ext oe", 16'hFFFF, EXT_DATA_PINS_OE)
		`CHK("ext o", 16'hA5C3, EXT_DATA_PINS_O)
		MEM_DRIVE <= 1'b0;
		@(posedge REF_CLK);
		`CHK("keep o", 16'hA5C3, EXT_DATA_KEEP_O)
		`CHK("keep oe", 16'hFFFF, EXT_DATA_KEEP_OE)
		`CHK("hkeep oe", 8'hFF, HOST_DATA_KEEP_OE)
		MEM_DRIVE <= 1'b1;
		BUS_HOLD <= 1'b1;
		@(posedge REF_CLK);
		`CHK("hold", 16'h0000, EXT_DATA_PINS_OE)
		BUS_HOLD <= 1'b0;
		OUTPUT_ENABLE_N <= 1'b0;
		LINE_INTERFACE_ENABLE_N <= 1'b0;
		@(posedge REF_CLK);
		`CHK("off", 16'h0000, EXT_DATA_PINS_OE)
		`CHK("hoff", 8'h00, HOST_DATA_PINS_OE)
		`CHK("line", 1'b1, LINE_INTERFACE_ON)
		OUTPUT_ENABLE_N <= 1'b1;
		MEM_DRIVE <= 1'b0;
		LINE_INTERFACE_ENABLE_N <= 1'b1;
	endtask
	task automatic t_wide();
		WIDE_HOST_MODE_PIN <= 1'b1;
		start <= 1'b1;
		@(posedge REF_CLK);
		start <= 1'b0;
		repeat (2) @(posedge REF_CLK);
		`CHK("act", 1'b1, HOST_ACTIVE)
		`CHK("addr", 16'h1234, HOST_ADDR)
		`CHK("wdata", 16'hBEEF, HOST_WDATA)
		`CHK("gpio", 8'hEF, GPIO_IN)
		WIDE_HOST_MODE_PIN <= 1'b0;
		@(posedge REF_CLK);
		`CHK("narrow", 16'h00EF, HOST_WDATA)
		`CHK("naddr", 16'h0000, HOST_ADDR)
	endtask
	task automatic t_gpio();
		WIDE_HOST_MODE_PIN <= 1'b1;
		wb(1'b1, hpp_pkg::ADDR_GPIO_OUT, 32'h0000_005A);
		wb(1'b1, hpp_pkg::ADDR_GPIO_DIR, 32'h0000_00FF);
		`CHK("gpio oe", 8'hFF, HOST_DATA_PINS_OE)
		`CHK("gpio o", 8'h5A, HOST_DATA_PINS_O)
		`CHK("gpio in", 8'h5A, GPIO_IN)
		wb(1'b0, hpp_pkg::ADDR_STATUS, 32'h0);
		`CHK("status", 32'h0000_0001, rd)
		WIDE_HOST_MODE_PIN <= 1'b0;
		@(posedge REF_CLK);
		`CHK("narrow oe", 8'h00, HOST_DATA_PINS_OE)
	endtask
	initial begin
		repeat (5) @(posedge REF_CLK);
		RST_N <= 1'b1;
		@(posedge REF_CLK);
		t_regs();
		t_pads();
		t_wide();
		t_gpio();
		finish_test();
	end
endmodule
bind hpp_top hpp_sva chk (.*);
